/* src/ldc_regs.vh */
// Constants of the display control block: commands, fields, resets, timing.
`ifndef LDC_REGS_VH
`define LDC_REGS_VH

// Command port selectors.
`define LDC_SEL_AREA 1'b0
`define LDC_SEL_CTRL 1'b1

// Display area command: [3:1] area base, [0] base frequency select.
`define LDC_AREA_RESET 4'h8
`define LDC_AREA_BASE_MSB 3
`define LDC_AREA_BASE_LSB 1
`define LDC_AREA_SLF_BIT 0
`define LDC_AREA_BASE_SHIFT 5

// Display control command: [3:2] command code, [1:0] duty field.
`define LDC_CTRL_RESET 4'h0
`define LDC_CTRL_EN_BIT 3
`define LDC_CTRL_CODE_MSB 3
`define LDC_CTRL_CODE_LSB 2
`define LDC_CTRL_DTY_MSB 1
`define LDC_CTRL_DTY_LSB 0

// Command codes in the upper two bits.
`define LDC_CODE_DUTY 2'h0
`define LDC_CODE_BLANK 2'h1
`define LDC_CODE_BAD 2'h2
`define LDC_CODE_ENABLE 2'h3

// Duty field encodings.
`define LDC_DTY_QUARTER 2'h0
`define LDC_DTY_THIRD 2'h1
`define LDC_DTY_HALF 2'h2
`define LDC_DTY_STATIC 2'h3

// Timing counts.
`define LDC_CLKS_PER_MCYC 4
`define LDC_MCYC_PER_ICYC 4
`define LDC_WORDS 24
`define LDC_WIN_DYNAMIC 512
`define LDC_WIN_STATIC 2048
`define LDC_ROW_CLKS 8192

`endif

/* src/ldc_timebase.v */
// Instruction cycle and common row step enables from the basic clock.
`timescale 1ns/100ps
`include "ldc_regs.vh"
module ldc_timebase
#(
  parameter ROW_CLKS = `LDC_ROW_CLKS
)
(
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Control
  input wire run,
  input wire base_frequency_select,
  // Enables
  output reg icyc_en_q,
  output reg row_en_q
);

localparam [3:0] ICYC_LAST =
  `LDC_CLKS_PER_MCYC * `LDC_MCYC_PER_ICYC - 1;
localparam [15:0] ROW_LAST = ROW_CLKS - 1;

reg [3:0] phase_q;
reg [15:0] row_cnt_q;
wire [15:0] row_last;

// Base select 1 halves the row period.
assign row_last = base_frequency_select ? {1'b0, ROW_LAST[15:1]} : ROW_LAST;

//////////////////////////////////////////////////////////////////////////////
// Both counters freeze and both enables stay low while run is low, so hold resumes mid-cycle.
always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    phase_q <= 4'h0;
    row_cnt_q <= 16'h0000;
    icyc_en_q <= 1'b0;
    row_en_q <= 1'b0;
  end
  else
  begin
    icyc_en_q <= 1'b0;
    row_en_q <= 1'b0;
    if (run)
    begin
      phase_q <= (phase_q == ICYC_LAST) ? 4'h0 : phase_q + 4'h1;
      icyc_en_q <= (phase_q == ICYC_LAST);
      if (row_cnt_q >= row_last)
      begin
        row_cnt_q <= 16'h0000;
        row_en_q <= 1'b1;
      end
      else
        row_cnt_q <= row_cnt_q + 16'h0001;
    end
  end
end

endmodule

/* src/ldc_display_control.v */
// Display control: command registers, display transfers and panel drive.
//
// Behaviour
// - With display enabled, segments and commons show the display area.
// - The first enable after reset closes the display power switch.
// - Reset clears the control register, sets area base 4, and opens the display power switch.
// - Control code 01 blanks, 11 enables, and 10 must not be written.
// - Quarter duty uses all four bits of each display word.
// - One-third duty uses only the low three bits of each word.
// - An instruction cycle is four machine cycles of four clocks each.
// - All control and transfers run on the single basic clock.
// - One hold input requests hold and release; state is kept across.
// - 24 transfers per 512 cycles, 2048 if static, halved by base select.
// - Each area bit is one segment and common pair; 1 lights it.
// - With enable 0 commons go non-lighting while segments keep running.
// - Hold opens the power switch and release restores the display.
`timescale 1ns/100ps
`include "ldc_regs.vh"
module ldc_display_control
#(
  parameter ROW_CLKS = `LDC_ROW_CLKS,
  parameter WORDS = `LDC_WORDS
)
(
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Hold pin, low requests hold
  input wire hold_n,
  // Command write port from the processor
  input wire cmd_wr,
  input wire cmd_sel,
  input wire [3:0] cmd_data,
  // Display transfer cycle with data memory
  output reg xfer_req_q,
  input wire xfer_gnt,
  output reg [7:0] mem_addr_q,
  input wire [3:0] mem_rdata,
  // Panel drive
  output reg [23:0] segment_electrode_output_q,
  output reg [3:0] common_electrode_output_q,
  output reg com_blank_q,
  output reg power_on_q
);

// Last common row index for each duty setting.
function [1:0] last_row;
  input [1:0] duty_select_field;
  begin
    case (duty_select_field)
      `LDC_DTY_QUARTER: last_row = 2'd3;
      `LDC_DTY_THIRD: last_row = 2'd2;
      `LDC_DTY_HALF: last_row = 2'd1;
      default: last_row = 2'd0;
    endcase
  end
endfunction

localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_REQ = 2'd1;
localparam [1:0] ST_DONE = 2'd2;
localparam [4:0] LAST_WORD = WORDS - 1;
localparam [11:0] WIN_DYN_LAST = `LDC_WIN_DYNAMIC - 1;
localparam [11:0] WIN_STA_LAST = `LDC_WIN_STATIC - 1;
localparam [3:0] AREA_RST = `LDC_AREA_RESET;

//////////////////////////////////////////////////////////////////////////////
// Hold pin synchroniser.
reg hold_s1_q;
reg hold_s2_q;
wire holding;

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    hold_s1_q <= 1'b1;
    hold_s2_q <= 1'b1;
  end
  else
  begin
    hold_s1_q <= hold_n;
    hold_s2_q <= hold_s1_q;
  end
end

assign holding = !hold_s2_q;

//////////////////////////////////////////////////////////////////////////////
// Command registers and power switch.
reg [2:0] area_base_q;
reg slf_q;
reg display_enable_bit_q;
reg [1:0] duty_select_field_q;
reg power_sw_q;
wire [1:0] cmd_code;

assign cmd_code = cmd_data[`LDC_CTRL_CODE_MSB:`LDC_CTRL_CODE_LSB];

// Commands are refused during hold; the processor is stopped then anyway.
always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    area_base_q <= AREA_RST[`LDC_AREA_BASE_MSB:`LDC_AREA_BASE_LSB];
    slf_q <= AREA_RST[`LDC_AREA_SLF_BIT];
    display_enable_bit_q <= 1'b0;
    duty_select_field_q <= 2'h0;
    power_sw_q <= 1'b0;
  end
  else if (cmd_wr && !holding)
  begin
    if (cmd_sel == `LDC_SEL_AREA)
    begin
      area_base_q <= cmd_data[`LDC_AREA_BASE_MSB:`LDC_AREA_BASE_LSB];
      slf_q <= cmd_data[`LDC_AREA_SLF_BIT];
    end
    else
    begin
      case (cmd_code)
        `LDC_CODE_DUTY:
          duty_select_field_q <=
            cmd_data[`LDC_CTRL_DTY_MSB:`LDC_CTRL_DTY_LSB];
        `LDC_CODE_BLANK:
          display_enable_bit_q <= 1'b0;
        `LDC_CODE_ENABLE:
        begin
          display_enable_bit_q <= 1'b1;
          power_sw_q <= 1'b1;
        end
        default:
          display_enable_bit_q <= display_enable_bit_q;
      endcase
    end
  end
end

// Blanking never opens the switch; only reset does, and hold masks it.
wire drive_live;
assign drive_live = power_sw_q && !holding;

//////////////////////////////////////////////////////////////////////////////
// Timebase.
wire icyc_en;
wire row_en;

ldc_timebase #(
  .ROW_CLKS(ROW_CLKS)
) i_ldc_timebase (
  .clk(clk),
  .arst_n(arst_n),
  .run(!holding),
  .base_frequency_select(slf_q),
  .icyc_en_q(icyc_en),
  .row_en_q(row_en)
);

//////////////////////////////////////////////////////////////////////////////
// Transfer window: a burst of 24 requests at each window start.
reg [11:0] win_cnt_q;
wire [11:0] win_last;
wire win_start;
reg [1:0] st_q;
reg [4:0] word_q;
reg [3:0] shadow_q [0:23];
wire [7:0] area_addr;
integer k;

assign win_last = (duty_select_field_q == `LDC_DTY_STATIC) ?
  (slf_q ? {1'b0, WIN_STA_LAST[11:1]} : WIN_STA_LAST) :
  (slf_q ? {1'b0, WIN_DYN_LAST[11:1]} : WIN_DYN_LAST);
assign win_start = icyc_en && drive_live && (win_cnt_q == 12'h000);
assign area_addr = {area_base_q, 5'h00};

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
    win_cnt_q <= 12'h000;
  else if (icyc_en && drive_live)
    win_cnt_q <= (win_cnt_q >= win_last) ? 12'h000 :
      win_cnt_q + 12'h001;
end

// A burst cut short by hold simply resumes afterwards.
always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    st_q <= ST_IDLE;
    word_q <= 5'h00;
    xfer_req_q <= 1'b0;
    mem_addr_q <= 8'h00;
    for (k = 0; k < 24; k = k + 1)
      shadow_q[k] <= 4'h0;
  end
  else
  begin
    case (st_q)
      ST_IDLE:
      begin
        if (win_start)
        begin
          st_q <= ST_REQ;
          word_q <= 5'h00;
          xfer_req_q <= 1'b1;
          mem_addr_q <= area_addr;
        end
      end
      ST_REQ:
      begin
        if (holding)
          xfer_req_q <= 1'b0;
        else if (xfer_gnt && xfer_req_q)
        begin
          shadow_q[word_q] <= mem_rdata;
          if (word_q == LAST_WORD)
          begin
            st_q <= ST_DONE;
            xfer_req_q <= 1'b0;
          end
          else
          begin
            word_q <= word_q + 5'h01;
            mem_addr_q <= area_addr + {3'h0, word_q + 5'h01};
          end
        end
        else
          xfer_req_q <= 1'b1;
      end
      ST_DONE:
        st_q <= ST_IDLE;
      default:
      begin
        st_q <= ST_IDLE;
        xfer_req_q <= 1'b0;
      end
    endcase
  end
end

//////////////////////////////////////////////////////////////////////////////
// Common row scan and panel drive.
reg [1:0] row_q;
reg [23:0] seg_d;
reg [3:0] com_d;
integer i;

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
    row_q <= 2'd0;
  else if (row_q > last_row(duty_select_field_q))
    row_q <= 2'd0;
  else if (row_en)
    row_q <= (row_q == last_row(duty_select_field_q)) ? 2'd0 :
      row_q + 2'd1;
end

// A row past the duty's last index is reset one clock later, so unused bits drive for at most one clock.
always @*
begin
  for (i = 0; i < 24; i = i + 1)
    seg_d[i] = shadow_q[i][row_q];
  com_d = 4'h0;
  com_d[row_q] = 1'b1;
end

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    segment_electrode_output_q <= 24'h000000;
    common_electrode_output_q <= 4'h0;
    com_blank_q <= 1'b1;
    power_on_q <= 1'b0;
  end
  else
  begin
    power_on_q <= drive_live;
    segment_electrode_output_q <= drive_live ? seg_d : 24'h000000;
    common_electrode_output_q <= drive_live ? com_d : 4'h0;
    com_blank_q <= !(drive_live && display_enable_bit_q);
  end
end

endmodule

/* verification/ldc_display_control_chk.sv */
// Port assertions of the display control block.
`timescale 1ns/100ps
module ldc_display_control_chk
#(
  parameter ROW_CLKS = 8192,
  parameter WORDS = 24
)
(
  // Clock, reset and command port
  input wire clk,
  input wire arst_n,
  input wire hold_n,
  input wire cmd_wr,
  input wire cmd_sel,
  input wire [3:0] cmd_data,
  // Transfer cycle and panel
  input wire xfer_req_q,
  input wire xfer_gnt,
  input wire [7:0] mem_addr_q,
  input wire [3:0] mem_rdata,
  input wire [23:0] segment_electrode_output_q,
  input wire [3:0] common_electrode_output_q,
  input wire com_blank_q,
  input wire power_on_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Three high samples of hold_n let the input synchroniser settle.
  sequence ctrl_wr(c);
    hold_n [*3] ##0 cmd_wr && cmd_sel && cmd_data[3:2] == c;
  endsequence
  sequence grant;
    xfer_req_q && xfer_gnt;
  endsequence
  power_up_a: assert property (ctrl_wr(2'h3) |-> ##[1:2] power_on_q
    && !com_blank_q) else $error("enable left display dark");
  blank_set_a: assert property (ctrl_wr(2'h1) |-> ##[1:2] com_blank_q)
    else $error("blank command ignored");
  hold_off_a: assert property (!hold_n [*4] |-> !power_on_q)
    else $error("power on in hold");
  dark_com_a: assert property (!power_on_q [*2] |->
    common_electrode_output_q == 4'h0) else $error("commons driven");
  addr_step_a: assert property (grant ##0 mem_addr_q[4:0] != 5'd23
    |=> mem_addr_q == $past(mem_addr_q) + 8'h1) else $error("bad step");
  burst_end_a: assert property (grant ##0
    mem_addr_q[4:0] == 5'(WORDS - 1) |=> !xfer_req_q)
    else $error("burst too long");
  addr_hold_a: assert property (xfer_req_q && !xfer_gnt |=>
    !xfer_req_q || $stable(mem_addr_q)) else $error("address moved");
  reset_dark_a: assert property ($rose(arst_n) |-> !power_on_q
    && com_blank_q) else $error("reset state wrong");
endmodule

bind ldc_display_control ldc_display_control_chk
  #(.ROW_CLKS(ROW_CLKS), .WORDS(WORDS)) i_ldc_display_control_chk (
  .clk(clk), .arst_n(arst_n), .hold_n(hold_n), .cmd_wr(cmd_wr),
  .cmd_sel(cmd_sel), .cmd_data(cmd_data), .xfer_req_q(xfer_req_q),
  .xfer_gnt(xfer_gnt), .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata),
  .segment_electrode_output_q(segment_electrode_output_q),
  .common_electrode_output_q(common_electrode_output_q),
  .com_blank_q(com_blank_q), .power_on_q(power_on_q));

/* verification/ldc_mem_model.sv */
// Data memory side of the display transfer cycle.
`timescale 1ns/100ps
module ldc_mem_model
(
  // Clock
  input wire clk,
  // Transfer cycle
  input wire xfer_req_q,
  input wire [7:0] mem_addr_q,
  output logic xfer_gnt,
  output logic [3:0] mem_rdata
);
  logic [3:0] mem [0:255];
  initial
  begin
    xfer_gnt = 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = i[0] ? 4'hf : 4'h7;
  end
  // Grants every other cycle, so the block must hold its address between.
  always @(posedge clk)
    xfer_gnt <= xfer_req_q && !xfer_gnt;
  // Outside a grant the data is inverted, so a late sample shows up.
  assign mem_rdata = xfer_gnt ? mem[mem_addr_q] : ~mem[mem_addr_q];
endmodule

/* verification/ldc_display_control_tb_top.sv */
// Self-checking bench of the display control block.
`timescale 1ns/100ps
module ldc_display_control_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hold_n = 1'b1;
  logic cmd_wr = 1'b0;
  logic cmd_sel = 1'b0;
  logic [3:0] cmd_data = 4'h0;
  logic xfer_req_q, xfer_gnt, com_blank_q, power_on_q;
  logic [7:0] mem_addr_q;
  logic [3:0] mem_rdata, common_electrode_output;
  logic [23:0] segment_electrode_output;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  ldc_display_control #(.ROW_CLKS(64)) i_ldc_display_control (
    .clk(clk), .arst_n(arst_n), .hold_n(hold_n), .cmd_wr(cmd_wr),
    .cmd_sel(cmd_sel), .cmd_data(cmd_data), .xfer_req_q(xfer_req_q),
    .xfer_gnt(xfer_gnt), .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata),
    .segment_electrode_output_q(segment_electrode_output), .common_electrode_output_q(common_electrode_output),
    .com_blank_q(com_blank_q), .power_on_q(power_on_q));
  ldc_mem_model i_ldc_mem_model (.clk(clk), .xfer_req_q(xfer_req_q),
    .mem_addr_q(mem_addr_q), .xfer_gnt(xfer_gnt), .mem_rdata(mem_rdata));
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // The run spans several windows; the static one alone is 16384 clocks.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic wr(logic sel, logic [3:0] d);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_sel = sel;
    cmd_data = d;
    @(negedge clk);
    cmd_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic wait_row(logic [3:0] m);
    // One step lets the word taken at the last grant reach the segments.
    @(negedge clk);
    for (int k = 0; k < 400 && common_electrode_output !== m; k++)
      @(negedge clk);
  endtask
  // Odd words hold 1111 and even words 0111.
  function automatic logic [23:0] row_exp(int r);
    for (int i = 0; i < 24; i++)
      row_exp[i] = (i % 2 == 1) || (r != 3);
  endfunction
  task automatic t_enable;
    int n;
    n = 0;
    chk("early req", xfer_req_q, 0);
    wr(1'b1, 4'hc);
    chk("power", power_on_q, 1);
    chk("blank", com_blank_q, 0);
    for (int k = 0; k < 100 && !xfer_req_q; k++)
      @(negedge clk);
    chk("first addr", mem_addr_q, 8'h80);
    for (int k = 0; k < 200 && xfer_req_q; k++)
    begin
      n += xfer_gnt;
      @(negedge clk);
    end
    chk("grants", n, 24);
    wait_row(4'h1);
    chk("row 0", segment_electrode_output, row_exp(0));
    wait_row(4'h8);
    chk("row 3", segment_electrode_output, row_exp(3));
  endtask
  task automatic t_gap(int exp);
    int t0;
    while (xfer_req_q)
      @(negedge clk);
    while (!xfer_req_q)
      @(negedge clk);
    t0 = cyc;
    while (xfer_req_q)
      @(negedge clk);
    while (!xfer_req_q)
      @(negedge clk);
    chk("window", cyc - t0, exp);
  endtask
  task automatic t_modes;
    int n;
    n = 0;
    wr(1'b1, 4'h1);
    for (int k = 0; k < 300; k++)
    begin
      n += common_electrode_output[3];
      @(negedge clk);
    end
    chk("row 3 used", n, 0);
    chk("blank kept", com_blank_q, 0);
    wr(1'b1, 4'h4);
    chk("blanked", {com_blank_q, power_on_q}, 2'b11);
    wr(1'b1, 4'h8);
    chk("code 10", com_blank_q, 1);
    wr(1'b0, 4'h9);
    wr(1'b1, 4'hc);
    chk("unblank", com_blank_q, 0);
  endtask
  task automatic t_static;
    wr(1'b1, 4'h3);
    t_gap(16384);
    chk("static com", common_electrode_output, 4'h1);
  endtask
  task automatic t_hold;
    while (xfer_req_q)
      @(negedge clk);
    hold_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("hold", {power_on_q, common_electrode_output}, 5'h00);
    hold_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("resume", {power_on_q, com_blank_q}, 2'b10);
    arst_n = 1'b0;
    @(negedge clk);
    chk("reset", {power_on_q, com_blank_q}, 2'b01);
    arst_n = 1'b1;
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    t_enable();
    t_gap(8192);
    t_modes();
    t_gap(4096);
    t_static();
    t_hold();
    test_done();
  end
endmodule
